// ---- verilog/dcal_pkg.sv ----
/*
 * Package for the inductor resistance calibration sequencer: register map,
 * field positions, reset values, timing and fixed-point formats.
 * Assumes a 25 MHz system clock and an AXI4-Lite register bus.
 */
package dcal_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] PWM_MODE_CONFIG_ADDR   = 8'h00;
    localparam logic [7:0] COMM_LOGIC_STATUS_ADDR = 8'h04;
    localparam logic [7:0] CURRENT_SENSE_GAIN_ADDR = 8'h08;
    localparam logic [7:0] CAL_STATE_ADDR         = 8'h0c;

    localparam int CAL_START_BIT = 3;
    localparam int CML_FAIL_BIT  = 0;
    localparam int ADDR_LSB      = 2;
    localparam int ADDR_W        = 8;

    // ------------------------------------------------------------------
    // Data formats
    // ------------------------------------------------------------------
    // Currents in mA (16 bit), duty in units of 1/1024, gain in 1/256 steps.
    localparam int CUR_W   = 16;
    localparam int DUTY_W  = 10;
    localparam int GAIN_W  = 16;
    localparam int DUTY_FRAC = 10;

    localparam logic [15:0] GAIN_RESET    = 16'h0100;
    localparam logic [15:0] MIN_IIN_MA    = 16'h000a;
    // Three percent of 1024 is 30.72, rounded up to 31.
    localparam logic [9:0]  MIN_DUTY      = 10'h01f;
    localparam int          GAIN_TOL_PCT  = 30;
    localparam int          PCT_FULL      = 100;

    localparam int SETTLE_MS   = 160;
    localparam int CLK_HZ      = 25_000_000;
    localparam int SETTLE_CYC  = SETTLE_MS * (CLK_HZ / 1000);

    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum {
        ST_IDLE,
        ST_SETTLE,
        ST_EVAL,
        ST_DIVIDE,
        ST_CHECK
    } dcal_state_type;

    typedef struct packed {
        logic [CUR_W-1:0]  iin_ma;
        logic [CUR_W-1:0]  iout_ma;
        logic [DUTY_W-1:0] duty;
    } dcal_tele_type;

endpackage

// ---- verilog/dcal_top.sv ----
/*
 * Inductor resistance auto-calibration sequencer with its AXI4-Lite slave.
 * Assumes telemetry inputs are synchronous to aclk and updated by the
 * device's own ADC path; the PWM enable is a level from the same clock.
 */
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps

// How it works
// - Writing one to bit 3 of pwm_mode_config starts a calibration run.
// - PWM output must stay enabled through the whole run, or it fails.
// - Duty reading below three percent at evaluation fails the run.
// - Input current reading below 10 mA at evaluation fails the run.
// - New gain more than 30 percent away from the old gain fails the run.
// - On failure set comm_logic_status bit 0 and keep the old gain.
// - On success gain is scaled so iout times duty equals iin.
module dcal_top #(
    parameter int SETTLE_CYCLES = dcal_pkg::SETTLE_CYC
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [dcal_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [dcal_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic                       pwm_enabled,
    input  wire dcal_pkg::dcal_tele_type    telemetry,
    output logic [dcal_pkg::GAIN_W-1:0]     current_sense_gain,
    output logic                            cal_busy
);
    import dcal_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
    localparam int NUM_W = CUR_W + DUTY_FRAC + GAIN_W;
    localparam int DIV_STEPS = NUM_W;
    // Eight extra bits so that gain times 130 percent cannot wrap.
    localparam int PROD_W = GAIN_W + 8;

    dcal_state_type          state_q;
    logic [CNT_W-1:0]        cnt_q;
    logic                    start_q;
    logic                    cml_fail_q;
    logic [GAIN_W-1:0]       gain_q;
    logic                    pwm_lost_q;
    logic [NUM_W-1:0]        num_q;
    logic [NUM_W-1:0]        quo_q;
    logic [NUM_W:0]          rem_q;
    logic [NUM_W-1:0]        den_q;
    logic [5:0]              step_q;
    logic                    aw_hold_q;
    logic                    w_hold_q;
    logic [ADDR_W-1:0]       awaddr_q;
    logic [31:0]             wdata_q;
    logic [3:0]              wstrb_q;
    logic                    bvalid_q;
    logic [1:0]              bresp_q;
    logic                    rvalid_q;
    logic [31:0]             rdata_q;
    logic [1:0]              rresp_q;

    logic                    wr_fire;
    logic                    start_write;
    logic                    cml_clear;
    logic                    run_done;
    logic                    run_fail;
    logic [NUM_W:0]          rem_shift;
    logic [PROD_W-1:0]       new_x100;
    logic [PROD_W-1:0]       lo_lim;
    logic [PROD_W-1:0]       hi_lim;

    assign current_sense_gain = gain_q;
    assign cal_busy           = (state_q != ST_IDLE);

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    // Address and data are latched independently; the response is issued
    // once both are held and the previous response has been taken.
    assign s_axi_awready = !aw_hold_q;
    assign s_axi_wready  = !w_hold_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign wr_fire       = aw_hold_q && w_hold_q && !bvalid_q;
    assign start_write   = wr_fire && (awaddr_q == PWM_MODE_CONFIG_ADDR) && wstrb_q[0]
                           && wdata_q[CAL_START_BIT];
    assign cml_clear     = wr_fire && (awaddr_q == COMM_LOGIC_STATUS_ADDR) && wstrb_q[0]
                           && wdata_q[CML_FAIL_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (s_axi_awvalid && !aw_hold_q) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= {s_axi_awaddr[ADDR_W-1:ADDR_LSB], 2'b00};
        end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (s_axi_wvalid && !w_hold_q) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= AXI_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (awaddr_q > CAL_STATE_ADDR) ? AXI_SLVERR : AXI_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= AXI_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= AXI_OKAY;
            rdata_q  <= '0;
            case ({s_axi_araddr[ADDR_W-1:ADDR_LSB], 2'b00})
                PWM_MODE_CONFIG_ADDR:    rdata_q[CAL_START_BIT] <= start_q;
                COMM_LOGIC_STATUS_ADDR:  rdata_q[CML_FAIL_BIT] <= cml_fail_q;
                CURRENT_SENSE_GAIN_ADDR: rdata_q[GAIN_W-1:0] <= gain_q;
                CAL_STATE_ADDR:          rdata_q[0] <= cal_busy;
                default:                 rresp_q <= AXI_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Gain register, start bit and failure flag
    // ------------------------------------------------------------------
    // Software may preload the gain only while no run is in progress, so a
    // run always compares against the gain it started from.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gain_q <= GAIN_RESET;
        end else if (state_q == ST_CHECK && !run_fail) begin
            gain_q <= quo_q[GAIN_W-1:0];
        end else if (wr_fire && awaddr_q == CURRENT_SENSE_GAIN_ADDR && !cal_busy) begin
            if (wstrb_q[0]) gain_q[7:0]  <= wdata_q[7:0];
            if (wstrb_q[1]) gain_q[15:8] <= wdata_q[15:8];
        end
    end

    assign run_done = (state_q == ST_CHECK);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_q <= 1'b0;
        end else if (run_done) begin
            start_q <= 1'b0;
        end else if (start_write) begin
            start_q <= 1'b1;
        end
    end

    // A failure in the same cycle as a software clear wins over the clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cml_fail_q <= 1'b0;
        end else if (run_done && run_fail) begin
            cml_fail_q <= 1'b1;
        end else if (cml_clear) begin
            cml_fail_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Settling wait gives the host's steady operating point time to reach
    // the telemetry before it is sampled.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q    <= ST_IDLE;
            cnt_q      <= '0;
            pwm_lost_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    pwm_lost_q <= 1'b0;
                    cnt_q      <= '0;
                    if (start_q && !run_done) begin
                        state_q <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (!pwm_enabled) pwm_lost_q <= 1'b1;
                    if (cnt_q == CNT_W'(SETTLE_CYCLES - 1)) begin
                        state_q <= ST_EVAL;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                ST_EVAL: begin
                    if (!pwm_enabled) pwm_lost_q <= 1'b1;
                    state_q <= ST_DIVIDE;
                end
                ST_DIVIDE: begin
                    if (!pwm_enabled) pwm_lost_q <= 1'b1;
                    if (step_q == 6'(DIV_STEPS)) state_q <= ST_CHECK;
                end
                ST_CHECK: state_q <= ST_IDLE;
                default:  state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Gain computation: new = old * iin / (iout * duty)
    // ------------------------------------------------------------------
    // A restoring divider is used instead of a wide combinational divide;
    // it costs one cycle per quotient bit, negligible against the settle.
    assign rem_shift = {rem_q[NUM_W-1:0], num_q[NUM_W-1]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            num_q  <= '0;
            den_q  <= '0;
            quo_q  <= '0;
            rem_q  <= '0;
            step_q <= '0;
        end else if (state_q == ST_EVAL) begin
            num_q  <= NUM_W'({telemetry.iin_ma, {DUTY_FRAC{1'b0}}}) * NUM_W'(gain_q);
            den_q  <= NUM_W'(telemetry.iout_ma) * NUM_W'(telemetry.duty);
            quo_q  <= '0;
            rem_q  <= '0;
            step_q <= '0;
        end else if (state_q == ST_DIVIDE && step_q != 6'(DIV_STEPS)) begin
            num_q  <= {num_q[NUM_W-2:0], 1'b0};
            step_q <= step_q + 1'b1;
            if (rem_shift >= {1'b0, den_q}) begin
                rem_q <= rem_shift - {1'b0, den_q};
                quo_q <= {quo_q[NUM_W-2:0], 1'b1};
            end else begin
                rem_q <= rem_shift;
                quo_q <= {quo_q[NUM_W-2:0], 1'b0};
            end
        end
    end

    logic eval_bad_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eval_bad_q <= 1'b0;
        end else if (state_q == ST_EVAL) begin
            eval_bad_q <= (telemetry.duty < MIN_DUTY)
                        || (telemetry.iin_ma < MIN_IIN_MA)
                        || (telemetry.iout_ma == '0);
        end
    end

    assign new_x100 = (quo_q[NUM_W-1:GAIN_W] != '0) ? '1
                    : PROD_W'(quo_q[GAIN_W-1:0]) * PROD_W'(PCT_FULL);
    assign lo_lim   = PROD_W'(gain_q) * PROD_W'(PCT_FULL - GAIN_TOL_PCT);
    assign hi_lim   = PROD_W'(gain_q) * PROD_W'(PCT_FULL + GAIN_TOL_PCT);
    assign run_fail = pwm_lost_q || !pwm_enabled || eval_bad_q
                    || (new_x100 < lo_lim) || (new_x100 > hi_lim);

endmodule

// ---- testbench/dcal_top_asserts.sv ----
/*
 * Concurrent checks on the ports of the calibration sequencer.
 * Assumes the bench binds it to the top module and passes SETTLE_CYCLES on.
 */
`timescale 1ns/1ps
module dcal_asserts #(
    parameter int SETTLE_CYCLES = 20
) (
    input wire logic                         aclk,
    input wire logic                         aresetn,
    input wire logic [dcal_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic                         s_axi_awvalid,
    input wire logic                         s_axi_awready,
    input wire logic [31:0]                  s_axi_wdata,
    input wire logic                         s_axi_wvalid,
    input wire logic                         s_axi_wready,
    input wire logic [1:0]                   s_axi_bresp,
    input wire logic                         s_axi_bvalid,
    input wire logic [dcal_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic                         s_axi_arvalid,
    input wire logic                         s_axi_arready,
    input wire logic [31:0]                  s_axi_rdata,
    input wire logic [1:0]                   s_axi_rresp,
    input wire logic                         s_axi_rvalid,
    input wire logic                         pwm_enabled,
    input wire dcal_pkg::dcal_tele_type      telemetry,
    input wire logic [dcal_pkg::GAIN_W-1:0] current_sense_gain,
    input wire logic                         cal_busy
);
    import dcal_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------------
    // Run length counter
    // ------------------------------------------------------------------
    logic [31:0] run_cnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !cal_busy) begin
            run_cnt_q <= 32'h0;
        end else begin
            run_cnt_q <= run_cnt_q + 32'h1;
        end
    end
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence start_taken;
        write_taken ##0 (s_axi_awaddr[7:2] == 6'h0 && s_axi_wdata[CAL_START_BIT]);
    endsequence
    sequence bad_wr;
        write_taken ##0 (s_axi_awaddr[7:2] > 6'h3);
    endsequence
    a_start_runs: assert property (start_taken |-> ##[2:3] cal_busy)
        else $error("calibration did not start");
    a_pwm_drop_keeps: assert property (
        cal_busy && !pwm_enabled |=> $stable(current_sense_gain))
        else $error("gain moved after pwm drop");
    a_duty_low_keeps: assert property (
        cal_busy && telemetry.duty < MIN_DUTY |=> $stable(current_sense_gain))
        else $error("gain moved with low duty");
    a_iin_low_keeps: assert property (
        cal_busy && telemetry.iin_ma < MIN_IIN_MA |=> $stable(current_sense_gain))
        else $error("gain moved with low input current");
    a_gain_in_band: assert property ($changed(current_sense_gain) && $past(cal_busy) |->
        32'(current_sense_gain) * 10 <= 32'($past(current_sense_gain)) * 13 &&
        32'(current_sense_gain) * 10 >= 32'($past(current_sense_gain)) * 7)
        else $error("calibrated gain outside band");
    a_run_ends: assert property (run_cnt_q <= 32'(SETTLE_CYCLES + 64))
        else $error("calibration run did not end");
    a_ar_refused: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not inverse of rvalid");
    a_write_answer: assert property (write_taken |-> ##[2:3] s_axi_bvalid)
        else $error("write response missing");
    a_bad_wr_addr: assert property (bad_wr |-> ##[2:3] (s_axi_bvalid && s_axi_bresp == AXI_SLVERR))
        else $error("unmapped write not refused");
    a_bad_rd_addr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h3
        |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0))
        else $error("unmapped read not refused");
endmodule

// ---- testbench/dcal_power_model.sv ----
/*
 * Power stage model: supplies telemetry and the PWM enable level.
 * Assumes the bench sets the operating point and may command a PWM drop.
 */
`timescale 1ns/1ps
module dcal_power_model (
    input wire logic                    aclk,
    input wire logic                    cal_busy,
    input wire logic                    pwm_set,
    input wire dcal_pkg::dcal_tele_type tele_set,
    output dcal_pkg::dcal_tele_type     telemetry,
    output logic                        pwm_enabled
);
    import dcal_pkg::*;
    always_ff @(posedge aclk) begin
        pwm_enabled <= pwm_set;
        // The operating point is frozen while a run measures it.
        if (!cal_busy) begin
            telemetry <= tele_set;
        end
    end
endmodule

// ---- testbench/inductor_dcr_auto_calibration_tb_top.sv ----
/*
 * Self-checking bench for the calibration sequencer.
 * Assumes the design package and the checker and power model files.
 */
`timescale 1ns/1ps
module inductor_dcr_auto_calibration_tb_top;
    import dcal_pkg::*;
    localparam int SETTLE_CYCLES = 20;
    logic          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic          awready, wready, bvalid, arready, rvalid, busy, pwm_set, pwm_en;
    logic [7:0]    awaddr, araddr;
    logic [31:0]   wdata, rdata, rd_q;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp, resp_q;
    logic [15:0]   gain, g_exp;
    dcal_tele_type tele_set, tele;
    int            bad_count, check_count;
    dcal_top #(.SETTLE_CYCLES(SETTLE_CYCLES)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_enabled(pwm_en),
        .telemetry(tele), .current_sense_gain(gain), .cal_busy(busy));
    dcal_power_model pm_u (.aclk(aclk), .cal_busy(busy), .pwm_set(pwm_set),
        .tele_set(tele_set), .telemetry(tele), .pwm_enabled(pwm_en));
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                bready <= 1'b0;
                resp_q = bresp;
                break;
            end
        end
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rready <= 1'b0;
                rd_q = rdata;
                resp_q = rresp;
                break;
            end
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic sc_regs();
        axi_rd(CURRENT_SENSE_GAIN_ADDR);
        chk("gain reset", {16'h0, GAIN_RESET}, rd_q);
        axi_rd(COMM_LOGIC_STATUS_ADDR);
        chk("status reset", 32'h0, rd_q);
        axi_rd(8'h10);
        chk("unmapped rresp", {30'h0, AXI_SLVERR}, {30'h0, resp_q});
        axi_wr(8'h10, 32'h1);
        chk("unmapped bresp", {30'h0, AXI_SLVERR}, {30'h0, resp_q});
        axi_wr(CURRENT_SENSE_GAIN_ADDR, 32'h200);
        chk("gain bresp", {30'h0, AXI_OKAY}, {30'h0, resp_q});
        axi_rd(CURRENT_SENSE_GAIN_ADDR);
        chk("gain written", 32'h200, rd_q);
        g_exp = 16'h200;
    endtask
    task automatic sc_cal(input logic [15:0] iin, input logic [15:0] iout,
                          input logic [9:0] duty, input logic drop);
        logic [63:0] ng;
        logic        ok;
        tele_set <= {iin, iout, duty};
        axi_wr(COMM_LOGIC_STATUS_ADDR, 32'h1);
        axi_wr(PWM_MODE_CONFIG_ADDR, 32'h8);
        @(negedge aclk);
        chk("busy", 32'h1, {31'h0, busy});
        axi_rd(CAL_STATE_ADDR);
        chk("state busy", 32'h1, rd_q);
        // A gain write during the run must be ignored.
        axi_wr(CURRENT_SENSE_GAIN_ADDR, 32'h300);
        if (drop) begin
            @(posedge aclk);
            pwm_set <= 1'b0;
            @(posedge aclk);
            pwm_set <= 1'b1;
        end
        for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge aclk);
        ng = (64'(g_exp) * iin * 1024) / (64'(iout) * duty);
        ok = !drop && duty >= MIN_DUTY && iin >= MIN_IIN_MA && ng * 10 >= 64'(g_exp) * 7
             && ng * 10 <= 64'(g_exp) * 13;
        if (ok) g_exp = ng[15:0];
        axi_rd(CURRENT_SENSE_GAIN_ADDR);
        chk("gain", {16'h0, g_exp}, rd_q);
        chk("gain port", {16'h0, g_exp}, {16'h0, gain});
        axi_rd(COMM_LOGIC_STATUS_ADDR);
        chk("fail flag", {31'h0, !ok}, rd_q);
        axi_rd(PWM_MODE_CONFIG_ADDR);
        chk("start bit", 32'h0, rd_q);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        results();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        pwm_set = 1'b1;
        tele_set = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        sc_regs();
        sc_cal(16'd1000, 16'd3600, 10'd256, 1'b0);
        sc_cal(16'd1000, 16'd3600, 10'd256, 1'b1);
        sc_cal(16'd1000, 16'd33000, 10'd30, 1'b0);
        sc_cal(16'd1000, 16'd33000, 10'd31, 1'b0);
        sc_cal(16'd9, 16'd36, 10'd256, 1'b0);
        sc_cal(16'd10, 16'd40, 10'd256, 1'b0);
        sc_cal(16'd1000, 16'd2000, 10'd256, 1'b0);
        results();
    end
endmodule
bind dcal_top dcal_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .pwm_enabled(pwm_enabled), .telemetry(telemetry),
    .current_sense_gain(current_sense_gain), .cal_busy(cal_busy));
